// *** logic/flash_status_map.vh ***
// constants for the flash status and read configuration front end
// assumes: included by bare name from the design files under logic/
//
// Function
// [RQ1] host writes status command to enter status reads
// [RQ2] after program, erase, lock sequences reads return status
// [RQ3] status on low byte, zeros on upper byte
// [RQ4] async read captures status on first enable fall
// [RQ5] sync reads need chip enable or valid toggle; the code refreshes the word only on an address valid fall with chip enable low
// [RQ6] async page status read valid first word only
// [RQ7] sync non-array read repeats word through burst
// [RQ8] bit 7 zero while busy, one when ready
// [RQ9] bit 6 erase suspend, bit 2 program suspend
// [RQ10] bits 5:4 encode program, erase, sequence error
// [RQ11] bit 3 set on low programming supply
// [RQ12] bit 1 set on locked block abort
// [RQ13] bit 0 high while factory buffer loads
// [RQ14] status default value is 0x80
// [RQ15] sequence error in suspend stays after resume
// [RQ16] host clears errors, waits fifteen microseconds
// [RQ17] clear command works regardless of supply level
// [RQ18] bits 7,6,2 live; 5,4,3,1 sticky until clear
// [RQ19] device reset clears all status flags
// [RQ20] read configuration is 16 bit, written by command
// [RQ21] configuration read at identifier offset 0x05
// [RQ22] reset selects asynchronous read mode
`ifndef FLASH_STATUS_MAP_VH
`define FLASH_STATUS_MAP_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_READ_ARRAY 8'hff
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_IDENT 8'h90
`define CMD_WORD_PROGRAM 8'h40
`define CMD_ERASE_SETUP 8'h20
`define CMD_BLANK_SETUP 8'hbc
`define CMD_FBUF_SETUP 8'h80
`define CMD_CONFIRM 8'hd0
`define CMD_SUSPEND 8'hb0
`define CMD_LOCK_SETUP 8'h60
`define CMD_LOCK 8'h01
`define CMD_LOCK_DOWN 8'h2f
`define CMD_CONFIG_WRITE 8'h03

// ----------------------------------------------------------------
// status word layout and reset
// ----------------------------------------------------------------
`define ST_READY_BIT 7
`define ST_ERASE_PAUSE_BIT 6
`define ST_ERASE_OUT_BIT 5
`define ST_PROG_OUT_BIT 4
`define ST_SUPPLY_BIT 3
`define ST_PROG_PAUSE_BIT 2
`define ST_LOCKED_BIT 1
`define ST_FACTORY_BIT 0
`define ST_RESET 8'h80
`define ST_UPPER_FILL 8'h00

// ----------------------------------------------------------------
// read configuration layout, reset and identifier offset
// ----------------------------------------------------------------
`define CFG_IDENT_OFFSET 8'h05
`define CFG_MODE_BIT 15
`define CFG_RESET 16'h8000
`define CFG_LEN_LSB 0
`define CFG_LEN_MSB 2
`define BURST_LEN_4 3'h1
`define BURST_LEN_8 3'h2
`define BURST_LEN_16 3'h3

`endif

// *** logic/pin_sync.v ***
// two-stage synchroniser for a group of pins
// assumes: inputs come from outside the ref_clk_i domain
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // first stage feeds only the second
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule // pin_sync

// *** logic/status_flags.v ***
// status word: live busy and suspend bits, sticky error bits
// assumes: event pulses and levels come from the ref_clk_i domain
`timescale 1ns/1ps
`include "flash_status_map.vh"
module status_flags (
  input wire ref_clk_i,
  input wire rst_i,
  input wire busy_i,
  input wire erase_pause_i,
  input wire program_pause_i,
  input wire factory_loading_i,
  input wire program_err_i,
  input wire erase_err_i,
  input wire seq_err_i,
  input wire supply_low_i,
  input wire locked_abort_i,
  input wire clear_i,
  output wire [7:0] status_o
);

  reg erase_outcome_flag_r;
  reg program_outcome_flag_r;
  reg supply_lockout_flag_r;
  reg locked_abort_flag_r;

  // sticky bits: set wins over a clear in the same cycle
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      erase_outcome_flag_r <= 1'b0; // RQ19
      program_outcome_flag_r <= 1'b0;
      supply_lockout_flag_r <= 1'b0;
      locked_abort_flag_r <= 1'b0;
    end else begin
      erase_outcome_flag_r <= erase_err_i | seq_err_i |
        (erase_outcome_flag_r & ~clear_i); // RQ10 RQ15 RQ18
      program_outcome_flag_r <= program_err_i | seq_err_i |
        (program_outcome_flag_r & ~clear_i); // RQ10 RQ17
      supply_lockout_flag_r <= supply_low_i |
        (supply_lockout_flag_r & ~clear_i); // RQ11
      locked_abort_flag_r <= locked_abort_i |
        (locked_abort_flag_r & ~clear_i); // RQ12
    end
  end

  // live bits follow the core; idle core gives the default word
  assign status_o[`ST_READY_BIT] = ~busy_i; // RQ8 RQ14
  assign status_o[`ST_ERASE_PAUSE_BIT] = erase_pause_i; // RQ9
  assign status_o[`ST_ERASE_OUT_BIT] = erase_outcome_flag_r;
  assign status_o[`ST_PROG_OUT_BIT] = program_outcome_flag_r;
  assign status_o[`ST_SUPPLY_BIT] = supply_lockout_flag_r;
  assign status_o[`ST_PROG_PAUSE_BIT] = program_pause_i; // RQ9
  assign status_o[`ST_LOCKED_BIT] = locked_abort_flag_r;
  assign status_o[`ST_FACTORY_BIT] = factory_loading_i; // RQ13

endmodule // status_flags

// *** logic/flash_status_top.v ***
// flash bus front end: command decode, status and config reads
// assumes: bus pins are asynchronous to ref_clk_i and are
// synchronised here; the array core signals share ref_clk_i
`timescale 1ns/1ps
`include "flash_status_map.vh"
module flash_status_top #(
  parameter ADDR_W = 26
) (
  input wire ref_clk_i,
  input wire rst_i,
  // parallel flash bus pins
  input wire chip_en_n_i,
  input wire out_en_n_i,
  input wire write_en_n_i,
  input wire address_valid_n_i,
  input wire bus_clk_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire [15:0] dq_i,
  output reg [15:0] dq_o,
  output reg dq_oe_n_o,
  // array core side
  input wire [15:0] array_data_i,
  input wire busy_i,
  input wire erase_pause_i,
  input wire program_pause_i,
  input wire factory_loading_i,
  input wire program_err_i,
  input wire erase_err_i,
  input wire supply_low_i,
  input wire locked_abort_i,
  output reg [ADDR_W-1:0] array_addr_o,
  output reg [7:0] op_cmd_o,
  output reg [15:0] op_data_o,
  output reg [ADDR_W-1:0] op_addr_o,
  output reg op_valid_o,
  output reg sync_mode_o
);

  // ----------------------------------------------------------------
  // local codes
  // ----------------------------------------------------------------
  localparam [1:0] RD_ARRAY = 2'd0;
  localparam [1:0] RD_STATUS = 2'd1;
  localparam [1:0] RD_IDENT = 2'd2;

  localparam [2:0] SQ_IDLE = 3'd0;
  localparam [2:0] SQ_PROGRAM = 3'd1;
  localparam [2:0] SQ_ERASE = 3'd2;
  localparam [2:0] SQ_LOCK = 3'd3;
  localparam [2:0] SQ_FBUF = 3'd4;
  localparam [2:0] SQ_BLANK = 3'd5;

  // burst length in beats; zero means continuous
  function [4:0] burst_beats;
    input [2:0] code;
    begin
      case (code)
        `BURST_LEN_4: burst_beats = 5'd4;
        `BURST_LEN_8: burst_beats = 5'd8;
        `BURST_LEN_16: burst_beats = 5'd16;
        default: burst_beats = 5'd0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [4:0] ctl_s;
  wire [ADDR_W-1:0] addr_s;
  wire [15:0] dq_s;

  pin_sync #(
    .WIDTH(5),
    .INIT(5'h0f)
  ) u_ctl_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i({bus_clk_i, address_valid_n_i, write_en_n_i, out_en_n_i,
      chip_en_n_i}),
    .sync_o(ctl_s)
  );

  // address and data are held stable around the strobes
  pin_sync #(
    .WIDTH(ADDR_W + 16),
    .INIT({(ADDR_W + 16){1'b0}})
  ) u_bus_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i({addr_i, dq_i}),
    .sync_o({addr_s, dq_s})
  );

  wire ce_n_s = ctl_s[0];
  wire oe_n_s = ctl_s[1];
  wire we_n_s = ctl_s[2];
  wire avl_n_s = ctl_s[3];
  wire bclk_s = ctl_s[4];

  // ----------------------------------------------------------------
  // edge detection on synchronised strobes
  // ----------------------------------------------------------------
  reg ce_n_d_r;
  reg oe_n_d_r;
  reg we_n_d_r;
  reg avl_n_d_r;
  reg bclk_d_r;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ce_n_d_r <= 1'b1;
      oe_n_d_r <= 1'b1;
      we_n_d_r <= 1'b1;
      avl_n_d_r <= 1'b1;
      bclk_d_r <= 1'b0;
    end else begin
      ce_n_d_r <= ce_n_s;
      oe_n_d_r <= oe_n_s;
      we_n_d_r <= we_n_s;
      avl_n_d_r <= avl_n_s;
      bclk_d_r <= bclk_s;
    end
  end

  wire ce_fall = ce_n_d_r & ~ce_n_s;
  wire oe_fall = oe_n_d_r & ~oe_n_s;
  wire avl_fall = avl_n_d_r & ~avl_n_s;
  wire bclk_rise = ~bclk_d_r & bclk_s;
  // a write is taken on the rising edge of write enable
  wire wr_take = ~we_n_d_r & we_n_s & ~ce_n_s;
  wire [7:0] wr_cmd = dq_s[7:0];

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  wire [7:0] status_live;
  reg seq_err_r;
  reg clear_r;

  status_flags u_status (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .busy_i(busy_i),
    .erase_pause_i(erase_pause_i),
    .program_pause_i(program_pause_i),
    .factory_loading_i(factory_loading_i),
    .program_err_i(program_err_i),
    .erase_err_i(erase_err_i),
    .seq_err_i(seq_err_r),
    .supply_low_i(supply_low_i),
    .locked_abort_i(locked_abort_i),
    .clear_i(clear_r),
    .status_o(status_live)
  );

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  reg [1:0] rd_mode_r;
  reg [2:0] seq_r;
  reg [15:0] read_mode_config_r;

  // setup commands wait for their second cycle; a wrong second
  // cycle is a sequence error and leaves status mode selected
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_mode_r <= RD_ARRAY;
      seq_r <= SQ_IDLE;
      read_mode_config_r <= `CFG_RESET; // RQ22
      seq_err_r <= 1'b0;
      clear_r <= 1'b0;
      op_cmd_o <= 8'h00;
      op_data_o <= 16'h0000;
      op_addr_o <= {ADDR_W{1'b0}};
      op_valid_o <= 1'b0;
    end else begin
      seq_err_r <= 1'b0;
      clear_r <= 1'b0;
      op_valid_o <= 1'b0;
      if (wr_take) begin
        op_addr_o <= addr_s;
        op_data_o <= dq_s;
        case (seq_r)
          SQ_PROGRAM: begin
            op_cmd_o <= `CMD_WORD_PROGRAM;
            op_valid_o <= 1'b1;
            rd_mode_r <= RD_STATUS; // RQ2
            seq_r <= SQ_IDLE;
          end
          SQ_ERASE, SQ_FBUF, SQ_BLANK: begin
            if (wr_cmd == `CMD_CONFIRM) begin
              op_cmd_o <= (seq_r == SQ_ERASE) ? `CMD_ERASE_SETUP :
                (seq_r == SQ_FBUF) ? `CMD_FBUF_SETUP : `CMD_BLANK_SETUP;
              op_valid_o <= 1'b1;
            end else begin
              seq_err_r <= 1'b1; // RQ10
            end
            rd_mode_r <= RD_STATUS; // RQ2
            seq_r <= SQ_IDLE;
          end
          SQ_LOCK: begin
            if (wr_cmd == `CMD_CONFIG_WRITE) begin
              read_mode_config_r <= addr_s[15:0]; // RQ20
              rd_mode_r <= RD_ARRAY;
            end else if (wr_cmd == `CMD_LOCK ||
                wr_cmd == `CMD_CONFIRM ||
                wr_cmd == `CMD_LOCK_DOWN) begin
              op_cmd_o <= wr_cmd;
              op_valid_o <= 1'b1;
              rd_mode_r <= RD_STATUS; // RQ2
            end else begin
              seq_err_r <= 1'b1; // RQ15
              rd_mode_r <= RD_STATUS;
            end
            seq_r <= SQ_IDLE;
          end
          default: begin
            case (wr_cmd)
              `CMD_READ_ARRAY: rd_mode_r <= RD_ARRAY;
              `CMD_READ_STATUS: rd_mode_r <= RD_STATUS;
              `CMD_READ_IDENT: rd_mode_r <= RD_IDENT;
              `CMD_CLEAR_STATUS: clear_r <= 1'b1; // RQ17
              `CMD_WORD_PROGRAM: seq_r <= SQ_PROGRAM;
              `CMD_ERASE_SETUP: seq_r <= SQ_ERASE;
              `CMD_FBUF_SETUP: seq_r <= SQ_FBUF;
              `CMD_BLANK_SETUP: seq_r <= SQ_BLANK;
              `CMD_LOCK_SETUP: seq_r <= SQ_LOCK;
              `CMD_SUSPEND, `CMD_CONFIRM: begin
                // suspend and resume go to the core, status follows
                op_cmd_o <= wr_cmd;
                op_valid_o <= 1'b1;
                rd_mode_r <= RD_STATUS;
              end
              default: begin
                seq_err_r <= 1'b1;
                rd_mode_r <= RD_STATUS;
              end
            endcase
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // read word selection
  // ----------------------------------------------------------------
  wire async_mode = read_mode_config_r[`CFG_MODE_BIT];
  wire non_array = (rd_mode_r != RD_ARRAY);
  reg [15:0] nonarray_word;

  always @* begin
    if (rd_mode_r == RD_STATUS)
      nonarray_word = {`ST_UPPER_FILL, status_live}; // RQ3
    else if (addr_s[7:0] == `CFG_IDENT_OFFSET)
      nonarray_word = read_mode_config_r; // RQ21
    else
      nonarray_word = 16'h0000;
  end

  // ----------------------------------------------------------------
  // read capture and burst sequencing
  // ----------------------------------------------------------------
  reg [15:0] held_word_r;
  reg armed_r;
  reg [ADDR_W-1:0] first_addr_r;
  reg [ADDR_W-1:0] burst_addr_r;
  reg [4:0] beat_r;
  reg [15:0] dq_nxt;
  reg burst_done;
  wire [4:0] burst_len =
    burst_beats(read_mode_config_r[`CFG_LEN_MSB:`CFG_LEN_LSB]);

  // the word is caught once per access, so status stays steady
  // while the host samples it even if the core moves on
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      held_word_r <= {`ST_UPPER_FILL, `ST_RESET}; // RQ14
      armed_r <= 1'b1;
      first_addr_r <= {ADDR_W{1'b0}};
      burst_addr_r <= {ADDR_W{1'b0}};
      beat_r <= 5'd0;
    end else if (async_mode) begin
      beat_r <= 5'd0;
      if (ce_n_s & oe_n_s) begin
        armed_r <= 1'b1;
      end else if (armed_r & (ce_fall | oe_fall)) begin
        held_word_r <= nonarray_word; // RQ4
        first_addr_r <= addr_s;
        armed_r <= 1'b0;
      end
    end else begin
      // only a new access start refreshes the word
      if (avl_fall & ~ce_n_s) begin
        held_word_r <= nonarray_word; // RQ5
        burst_addr_r <= addr_s;
        beat_r <= 5'd0;
      end else if (bclk_rise & ~oe_n_s & ~ce_n_s & ~burst_done) begin
        beat_r <= beat_r + 5'd1; // RQ7
        burst_addr_r <= burst_addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
      armed_r <= 1'b1;
    end
  end

  always @* begin
    burst_done = (burst_len != 5'd0) && (beat_r >= burst_len);
  end

  // output data: page words after the first are undefined, driven
  // as zero rather than left floating
  always @* begin
    if (async_mode) begin
      if (!non_array)
        dq_nxt = array_data_i;
      else if (addr_s == first_addr_r)
        dq_nxt = held_word_r;
      else
        dq_nxt = 16'h0000; // RQ6
    end else begin
      dq_nxt = non_array ? held_word_r : array_data_i; // RQ7
    end
  end

  // ----------------------------------------------------------------
  // registered pin outputs
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_o <= 16'h0000;
      dq_oe_n_o <= 1'b1;
      array_addr_o <= {ADDR_W{1'b0}};
      sync_mode_o <= 1'b0;
    end else begin
      dq_o <= dq_nxt;
      dq_oe_n_o <= ce_n_s | oe_n_s | ~we_n_s;
      array_addr_o <= async_mode ? addr_s : burst_addr_r;
      sync_mode_o <= ~async_mode;
    end
  end

endmodule // flash_status_top

// *** testbench/flash_status_checker.sv ***
// checker: timing relations at the flash front end pins
// assumes: bound onto flash_status_top, ref_clk_i domain only
`timescale 1ns/1ps
module flash_status_checker #(
  parameter ADDR_W = 26
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire chip_en_n_i,
  input wire out_en_n_i,
  input wire write_en_n_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire [15:0] dq_o,
  input wire dq_oe_n_o,
  input wire op_valid_o,
  input wire sync_mode_o
);
  // ------------------------------------------------------------
  // helper: cycles since the raw write pin last rose
  // ------------------------------------------------------------
  reg we_d_r;
  reg [3:0] we_age_r;
  // saturates so an old write never looks recent again
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      we_d_r <= 1'b1;
      we_age_r <= 4'hf;
    end else begin
      we_d_r <= write_en_n_i;
      if (write_en_n_i && !we_d_r) begin
        we_age_r <= 4'h0;
      end else if (we_age_r != 4'hf) begin
        we_age_r <= we_age_r + 4'h1;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  op_cause_a:
    assert property (op_valid_o |-> (we_age_r >= 4'h1 && we_age_r <= 4'h6))
    else $error("operation pulse without a bus write");
  op_pulse_a:
    assert property (op_valid_o |=> !op_valid_o)
    else $error("operation pulse longer than one cycle");
  mode_cause_a:
    assert property ($changed(sync_mode_o) |-> we_age_r < 4'h8)
    else $error("read mode changed without a write");
  reset_async_a:
    assert property ($fell(rst_i) |-> !sync_mode_o)
    else $error("read mode not asynchronous after reset");
  idle_oe_a:
    assert property (out_en_n_i [*6] |-> dq_oe_n_o)
    else $error("data driven with output enable high");
  idle_ce_a:
    assert property (chip_en_n_i [*6] |-> dq_oe_n_o)
    else $error("data driven with chip deselected");
  async_drive_a:
    assert property ((!sync_mode_o && !chip_en_n_i && !out_en_n_i) [*7]
      |-> !dq_oe_n_o)
    else $error("async read not driven in time");
  word_latch_a:
    assert property ((!chip_en_n_i && !out_en_n_i && $stable(addr_i)) [*8]
      |-> $stable(dq_o))
    else $error("read word changed during one access");
endmodule // flash_status_checker

bind flash_status_top flash_status_checker #(.ADDR_W(ADDR_W)) u_chk (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .chip_en_n_i(chip_en_n_i),
  .out_en_n_i(out_en_n_i),
  .write_en_n_i(write_en_n_i),
  .addr_i(addr_i),
  .dq_o(dq_o),
  .dq_oe_n_o(dq_oe_n_o),
  .op_valid_o(op_valid_o),
  .sync_mode_o(sync_mode_o)
);

// *** testbench/host_bus_model.sv ***
// host controller model: drives the parallel flash bus pins
// assumes: ref_clk_i is the device clock; the bench calls tasks
`timescale 1ns/1ps
module host_bus_model (
  input wire ref_clk_i,
  input wire [15:0] dq_i,
  output reg chip_en_n_o,
  output reg out_en_n_o,
  output reg write_en_n_o,
  output reg address_valid_n_o,
  output reg bus_clk_o,
  output reg [25:0] addr_o,
  output reg [15:0] dq_o
);
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // idle bus, bus clock stands still outside bursts
  initial begin
    {chip_en_n_o, out_en_n_o, write_en_n_o, address_valid_n_o} = 4'hf;
    bus_clk_o = 1'b0;
    addr_o = 26'h0;
    dq_o = 16'h0;
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk_i);
      #1;
    end
  endtask
  // pins held far past the two-stage sync window
  task wr(input [25:0] a, input [15:0] d);
    begin
      addr_o = a;
      dq_o = d;
      chip_en_n_o = 1'b0;
      write_en_n_o = 1'b0;
      tick(6);
      write_en_n_o = 1'b1;
      tick(6);
      chip_en_n_o = 1'b1;
      dq_o = ~d; // released lines must not keep the value
      tick(6);
    end
  endtask
  task rd(input [25:0] a, output [15:0] d);
    begin
      addr_o = a;
      chip_en_n_o = 1'b0;
      out_en_n_o = 1'b0;
      tick(8);
      d = dq_i;
      chip_en_n_o = 1'b1;
      out_en_n_o = 1'b1;
      tick(5);
    end
  endtask
  // four-beat burst, bus clock unrelated in phase to ref_clk_i
  task srd(input [25:0] a, output [63:0] w);
    integer i;
    begin
      addr_o = a;
      chip_en_n_o = 1'b0;
      address_valid_n_o = 1'b0;
      tick(4);
      address_valid_n_o = 1'b1;
      out_en_n_o = 1'b0;
      tick(4);
      for (i = 0; i < 4; i = i + 1) begin
        #62.5 bus_clk_o = 1'b1;
        #50 w[16*i +: 16] = dq_i;
        #12.5 bus_clk_o = 1'b0;
      end
      chip_en_n_o = 1'b1;
      out_en_n_o = 1'b1;
      tick(5);
    end
  endtask
endmodule // host_bus_model

// *** testbench/test_flash_status_and_read_config.sv ***
// bench: flash status front end against a behavioural model
// assumes: host_bus_model drives the bus, the bench the core side
`timescale 1ns/1ps
`include "flash_status_map.vh"
module test_flash_status_and_read_config;
  reg ref_clk_i, rst_i, busy_i, erase_pause_i, program_pause_i;
  reg factory_loading_i, program_err_i, erase_err_i;
  reg supply_low_i, locked_abort_i;
  reg [15:0] array_data_i, rdat;
  reg [31:0] rnd;
  reg [63:0] burst;
  wire ce_n, oe_n, we_n, avl_n, bclk, dq_oe_n, op_valid, sync_mode;
  wire [25:0] addr, op_addr, arr_addr;
  wire [15:0] host_dq, dev_dq, op_data;
  wire [7:0] op_cmd;
  integer mismatches, n_compared, seed, sticky, i, k;

  host_bus_model u_host_bus_model (.ref_clk_i(ref_clk_i), .dq_i(dev_dq),
    .chip_en_n_o(ce_n), .out_en_n_o(oe_n), .write_en_n_o(we_n),
    .address_valid_n_o(avl_n), .bus_clk_o(bclk), .addr_o(addr),
    .dq_o(host_dq));
  flash_status_top u_flash_status_top (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .chip_en_n_i(ce_n), .out_en_n_i(oe_n),
    .write_en_n_i(we_n), .address_valid_n_i(avl_n), .bus_clk_i(bclk),
    .addr_i(addr), .dq_i(host_dq), .dq_o(dev_dq), .dq_oe_n_o(dq_oe_n),
    .array_data_i(array_data_i), .busy_i(busy_i),
    .erase_pause_i(erase_pause_i), .program_pause_i(program_pause_i),
    .factory_loading_i(factory_loading_i), .program_err_i(program_err_i),
    .erase_err_i(erase_err_i), .supply_low_i(supply_low_i),
    .locked_abort_i(locked_abort_i), .array_addr_o(arr_addr),
    .op_cmd_o(op_cmd), .op_data_o(op_data), .op_addr_o(op_addr),
    .op_valid_o(op_valid), .sync_mode_o(sync_mode));

  // ------------------------------------------------------------
  // clock, model and helpers
  // ------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // status word as the rules build it from levels and sticky bits
  function automatic [15:0] exp_sr();
    exp_sr = {8'h00, ~busy_i, erase_pause_i, sticky[5:3], program_pause_i,
      sticky[1], factory_loading_i};
  endfunction
  task check(input [63:0] name, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge ref_clk_i);
      #1;
    end
  endtask
  task pulse(input integer n);
    begin
      {program_err_i, erase_err_i, supply_low_i, locked_abort_i} =
        4'h8 >> n;
      cyc(1);
      {program_err_i, erase_err_i, supply_low_i, locked_abort_i} = 4'h0;
    end
  endtask
  // hang guard, far beyond the longest sequence
  initial begin
    #400000;
    mismatches = mismatches + 1;
    end_sim;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hb2a1;
    {mismatches, n_compared, sticky} = 0;
    {busy_i, erase_pause_i, program_pause_i, factory_loading_i} = 4'h0;
    {program_err_i, erase_err_i, supply_low_i, locked_abort_i} = 4'h0;
    array_data_i = 16'h0;
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    cyc(1);
    check("mode", {15'h0, sync_mode}, 16'h0);
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_READ_IDENT});
    u_host_bus_model.rd(26'h5, rdat);
    check("cfg", rdat, `CFG_RESET);
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_READ_STATUS});
    // every combination of the live levels, fresh on each read
    for (i = 0; i < 16; i = i + 1) begin
      {busy_i, erase_pause_i, program_pause_i, factory_loading_i} = i;
      rnd = $random(seed);
      u_host_bus_model.rd(rnd[25:0], rdat);
      check("status", rdat, exp_sr());
    end
    {busy_i, erase_pause_i, program_pause_i, factory_loading_i} = 4'h0;
    // sticky flags pile up until the clear command
    for (k = 0; k < 4; k = k + 1) begin
      pulse(k);
      sticky = sticky | (k == 0 ? 16 : k == 1 ? 32 : k == 2 ? 8 : 2);
      u_host_bus_model.rd(26'h0, rdat);
      check("status", rdat, exp_sr());
    end
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_CLEAR_STATUS});
    sticky = 0;
    cyc(1875);
    u_host_bus_model.rd(26'h0, rdat);
    check("status", rdat, exp_sr());
    // sequence error while erase is suspended survives the resume
    erase_pause_i = 1'b1;
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_LOCK_SETUP});
    u_host_bus_model.wr(26'h0, 16'h0055);
    sticky = 48;
    u_host_bus_model.rd(26'h0, rdat);
    check("status", rdat, exp_sr());
    erase_pause_i = 1'b0;
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_CONFIRM});
    u_host_bus_model.rd(26'h0, rdat);
    check("status", rdat, exp_sr());
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_CLEAR_STATUS});
    sticky = 0;
    cyc(1875);
    // program sequence turns reads to status until read-array
    rnd = $random(seed);
    array_data_i = rnd[15:0];
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_READ_ARRAY});
    u_host_bus_model.rd(rnd[25:0], rdat);
    check("array", rdat, array_data_i);
    u_host_bus_model.wr(rnd[25:0], {8'h00, `CMD_WORD_PROGRAM});
    u_host_bus_model.wr(rnd[25:0], rnd[31:16]);
    check("op_cmd", {8'h00, op_cmd}, {8'h00, `CMD_WORD_PROGRAM});
    check("op_data", op_data, rnd[31:16]);
    check("op_addr", op_addr[15:0], rnd[15:0]);
    u_host_bus_model.rd(rnd[25:0], rdat);
    check("status", rdat, exp_sr());
    // erase setup and confirm hand one erase to the core
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_ERASE_SETUP});
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_CONFIRM});
    check("op_cmd", {8'h00, op_cmd}, {8'h00, `CMD_ERASE_SETUP});
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_READ_ARRAY});
    u_host_bus_model.rd(rnd[25:0], rdat);
    check("array", rdat, array_data_i);
    // config write and read back, then a synchronous status burst
    u_host_bus_model.wr(26'h8002, {8'h00, `CMD_LOCK_SETUP});
    u_host_bus_model.wr(26'h8002, {8'h00, `CMD_CONFIG_WRITE});
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_READ_IDENT});
    u_host_bus_model.rd(26'h5, rdat);
    check("cfg", rdat, 16'h8002);
    u_host_bus_model.wr(26'h0001, {8'h00, `CMD_LOCK_SETUP});
    u_host_bus_model.wr(26'h0001, {8'h00, `CMD_CONFIG_WRITE});
    check("mode", {15'h0, sync_mode}, 16'h1);
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_READ_STATUS});
    u_host_bus_model.srd(26'h0, burst);
    for (i = 0; i < 4; i = i + 1)
      check("burst", burst[16*i +: 16], exp_sr());
    // four rises, four-beat length: address stops at start plus four
    check("baddr", arr_addr[15:0], 16'h0004);
    // reset in mid-run drops flags and config
    pulse(0);
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    sticky = 0;
    cyc(1);
    check("mode", {15'h0, sync_mode}, 16'h0);
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_READ_STATUS});
    u_host_bus_model.rd(26'h0, rdat);
    check("status", rdat, `ST_RESET);
    u_host_bus_model.wr(26'h0, {8'h00, `CMD_READ_IDENT});
    u_host_bus_model.rd(26'h5, rdat);
    check("cfg", rdat, `CFG_RESET);
    end_sim;
  end
endmodule // test_flash_status_and_read_config
